// file: rtl/ffm_params.svh
// offsets, field positions and reset values of the freefall/motion detector
`ifndef FFM_PARAMS_SVH
`define FFM_PARAMS_SVH

// register offsets
`define FFM_OFS_CONFIG 8'h15
`define FFM_OFS_SOURCE 8'h16
`define FFM_OFS_THRESH 8'h17
`define FFM_OFS_COUNT 8'h18

// configuration register fields
`define FFM_CFG_LATCH_BIT 7
`define FFM_CFG_OR_BIT 6
`define FFM_CFG_Z_BIT 5
`define FFM_CFG_Y_BIT 4
`define FFM_CFG_X_BIT 3

// threshold register fields
`define FFM_THS_MODE_BIT 7
`define FFM_THS_MSB 6

// source register fields
`define FFM_SRC_EA_BIT 7

// reset values
`define FFM_RST_CONFIG 8'h00
`define FFM_RST_THRESH 8'h00
`define FFM_RST_COUNT 8'h00
`define FFM_RST_ZERO 8'h00

`endif

// file: rtl/ffm_pkg.sv
// types shared by the freefall/motion detector
package ffm_pkg;

	// one acceleration sample per axis, signed, 0.063 g per count
	typedef logic signed [7:0] ffm_accel_t;

	typedef struct packed {
		ffm_accel_t z;
		ffm_accel_t y;
		ffm_accel_t x;
	} ffm_sample_s;

	// configuration register image
	typedef struct packed {
		logic latch_on;
		logic or_select;
		logic z_on;
		logic y_on;
		logic x_on;
	} ffm_cfg_s;

	// per-axis flag pair as held in the source register
	typedef struct packed {
		logic high;
		logic sign;
	} ffm_flag_s;

	// z, y, x from msb down, matching the source register order
	typedef ffm_flag_s [2:0] ffm_flags_t;

endpackage : ffm_pkg

// file: rtl/ffm_axis_cmp.sv
// per-axis magnitude compare against the threshold
`timescale 1ns/1ps

module ffm_axis_cmp (
	// sample and threshold
	input wire ffm_pkg::ffm_accel_t accel,
	input wire logic [6:0] threshold,
	// compare results
	output logic above,
	output logic at_or_below,
	output logic negative
);
	logic [7:0] mag;

	// -128 maps to 128, which still fits an unsigned byte
	assign mag = accel[7] ? (8'h00 - accel) : accel;
	assign above = mag > {1'b0, threshold};
	assign at_or_below = !above;
	assign negative = accel[7];

endmodule : ffm_axis_cmp

// file: rtl/ffm_detector.sv
// freefall/motion detector: config registers, combination, debounce and source flags
`timescale 1ns/1ps
`include "ffm_params.svh"

// Behaviour
// - OR mode unlatched, event flag rises only when debounce counter hits target.
// - only enabled axes take part in the freefall or motion combination.
// - unlatched, decrement mode, event flag clears only when counter decays to zero.
// - unlatched, clear mode, event flag drops as soon as condition lapses.
// - unlatched, axis flags follow live undebounced high status of enabled axes.
// - unlatched, reading the source register changes nothing.
// - latched, event flag sets at full count and holds until source read.
// - latched, source read clears all source bits and the debounce counter.
// - latched, axis flags live while event clear, frozen once it sets.
// - config holds latch, combine, z/y/x enables at 7..3; low bits zero.
// - combine bit 0 is AND of low conditions, 1 is OR of high.
// - axis low condition is magnitude at or below threshold.
// - axis high condition is magnitude strictly above threshold.
// - one unsigned 7-bit threshold on magnitude serves both modes.
// - source holds event at 7, zero at 6, z/y/x flag and sign below.
// - axis flag and sign read zero while that axis is disabled.
// - sign flag is 0 for positive, 1 for negative acceleration on a high axis; 0 while the axis is not high.
// - interrupt outputs are event flag gated by enable and routing.
// - latched with event held, new axis events leave the source untouched.
// - on lapse, decrement mode steps counter down one, clear mode zeroes it.
// - debounce counter saturates at the programmed target.
// - threshold is 0.063 g per count over 0 to 127.
module ffm_detector (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register port: reg_rd marks a completed read of reg_addr
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// acceleration samples, one valid pulse per output data period
	input wire logic sample_valid,
	input wire ffm_pkg::ffm_sample_s sample,
	// interrupt enable and routing bits
	input wire logic motion_irq_enable,
	input wire logic motion_irq_route,
	// interrupt outputs, active high
	output logic irq_int1,
	output logic irq_int2
);
	// register state
	ffm_pkg::ffm_cfg_s cfg_q;
	logic debounce_lapse_mode_q;
	logic [6:0] accel_threshold_q; // 0.063 g per count, 0..127
	logic [7:0] debounce_target_count_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic event_active_flag_q;
	logic ea_d;
	ffm_pkg::ffm_flags_t flags_q;
	ffm_pkg::ffm_flags_t flags_d;
	logic [7:0] reg_rdata_q;
	logic irq_int1_q;
	logic irq_int2_q;

	// decode
	wire wr_cfg = reg_wr && (reg_addr == `FFM_OFS_CONFIG);
	wire wr_ths = reg_wr && (reg_addr == `FFM_OFS_THRESH);
	wire wr_cnt = reg_wr && (reg_addr == `FFM_OFS_COUNT);
	wire rd_src = reg_rd && (reg_addr == `FFM_OFS_SOURCE);
	wire [2:0] axis_on = {cfg_q.z_on, cfg_q.y_on, cfg_q.x_on};

	// per-axis compare, one shared threshold for both modes
	logic [2:0] above;
	logic [2:0] low;
	logic [2:0] neg;
	ffm_axis_cmp u_cmp_x (
		.accel(sample.x),
		.threshold(accel_threshold_q),
		.above(above[0]),
		.at_or_below(low[0]),
		.negative(neg[0])
	);
	ffm_axis_cmp u_cmp_y (
		.accel(sample.y),
		.threshold(accel_threshold_q),
		.above(above[1]),
		.at_or_below(low[1]),
		.negative(neg[1])
	);
	ffm_axis_cmp u_cmp_z (
		.accel(sample.z),
		.threshold(accel_threshold_q),
		.above(above[2]),
		.at_or_below(low[2]),
		.negative(neg[2])
	);

	// combination: disabled axes drop out; no axis enabled means the block is off
	wire any_on = |axis_on;
	wire or_cond = |(axis_on & above);
	wire and_cond = any_on && (&(~axis_on | low));
	wire cond = cfg_q.or_select ? or_cond : and_cond;

	// live per-axis flags; sign only meaningful while the axis is high
	function automatic ffm_pkg::ffm_flags_t live_flags(input logic [2:0] hi, input logic [2:0] sg,
			input logic [2:0] en);
		ffm_pkg::ffm_flags_t f;
		f = '0;
		for (int i = 0; i < 3; i++) begin
			f[i].high = hi[i] && en[i];
			f[i].sign = hi[i] && en[i] && sg[i]; // negative g reads 1
		end
		return f;
	endfunction : live_flags

	wire ffm_pkg::ffm_flags_t live = live_flags(above, neg, axis_on);

	// a latched read wipes counter, event and flags before the sample lands,
	// so an event in the same cycle as the read is rebuilt, not lost
	wire clr_rd = rd_src && cfg_q.latch_on;
	wire [7:0] cnt_base = clr_rd ? 8'h00 : cnt_q;
	wire ea_base = clr_rd ? 1'b0 : event_active_flag_q;
	wire ffm_pkg::ffm_flags_t flags_base = clr_rd ? ffm_pkg::ffm_flags_t'(6'h00) : flags_q;

	// counter step: up to target while true, decay or clear on lapse
	wire [7:0] cnt_up = (cnt_base >= debounce_target_count_q) ? debounce_target_count_q
		: cnt_base + 8'h01;
	wire [7:0] cnt_down = debounce_lapse_mode_q ? 8'h00
		: ((cnt_base == 8'h00) ? 8'h00 : cnt_base - 8'h01);
	wire [7:0] cnt_step = cond ? cnt_up : cnt_down;
	wire reached = cond && (cnt_step == debounce_target_count_q);

	// next state, updated on a new sample or cleared by a latched source read
	always_comb begin
		cnt_d = cnt_base;
		ea_d = ea_base;
		flags_d = flags_base;
		if (sample_valid) begin
			cnt_d = cnt_step;
			if (cfg_q.latch_on) begin
				if (!ea_base) begin
					flags_d = live;
					ea_d = reached;
				end
			end else begin
				flags_d = live;
				if (reached) begin
					ea_d = 1'b1;
				end else if (!cond && debounce_lapse_mode_q) begin
					ea_d = 1'b0;
				end else if (cnt_step == 8'h00) begin
					ea_d = 1'b0;
				end
			end
		end
	end

	// source image: disabled axes always read zero
	function automatic logic [7:0] src_image(input logic ea, input ffm_pkg::ffm_flags_t f,
			input logic [2:0] en);
		logic [5:0] m;
		m = {{2{en[2]}}, {2{en[1]}}, {2{en[0]}}};
		return {ea, 1'b0, f & m};
	endfunction : src_image

	wire [7:0] src_view = src_image(event_active_flag_q, flags_q, axis_on);
	wire [7:0] cfg_view = {cfg_q, 3'b000};
	wire [7:0] rdata_d = (reg_addr == `FFM_OFS_CONFIG) ? cfg_view
		: (reg_addr == `FFM_OFS_SOURCE) ? src_view
		: (reg_addr == `FFM_OFS_THRESH) ? {debounce_lapse_mode_q, accel_threshold_q}
		: (reg_addr == `FFM_OFS_COUNT) ? debounce_target_count_q
		: `FFM_RST_ZERO;

	// host-written registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= ffm_pkg::ffm_cfg_s'(5'h00);
			debounce_lapse_mode_q <= 1'b0;
			accel_threshold_q <= 7'h00;
			debounce_target_count_q <= `FFM_RST_COUNT;
		end else begin
			if (wr_cfg) cfg_q <= reg_wdata[`FFM_CFG_LATCH_BIT:`FFM_CFG_X_BIT];
			if (wr_ths) debounce_lapse_mode_q <= reg_wdata[`FFM_THS_MODE_BIT];
			if (wr_ths) accel_threshold_q <= reg_wdata[`FFM_THS_MSB:0];
			if (wr_cnt) debounce_target_count_q <= reg_wdata;
		end
	end

	// detector state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 8'h00;
			event_active_flag_q <= 1'b0;
			flags_q <= ffm_pkg::ffm_flags_t'(6'h00);
		end else begin
			cnt_q <= cnt_d;
			event_active_flag_q <= ea_d;
			flags_q <= flags_d;
		end
	end

	// read data is captured on the same edge that the clear acts, from pre-clear state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_q <= `FFM_RST_ZERO;
		end else if (reg_rd) begin
			reg_rdata_q <= rdata_d;
		end
	end

	// interrupt gating; route 1 selects the first pin
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_int1_q <= 1'b0;
			irq_int2_q <= 1'b0;
		end else begin
			irq_int1_q <= event_active_flag_q && motion_irq_enable && motion_irq_route;
			irq_int2_q <= event_active_flag_q && motion_irq_enable && !motion_irq_route;
		end
	end

	assign reg_rdata = reg_rdata_q;
	assign irq_int1 = irq_int1_q;
	assign irq_int2 = irq_int2_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_latched_read;
		rd_src && cfg_q.latch_on && !sample_valid && !reg_wr;
	endsequence

	sequence s_all_cleared;
		!event_active_flag_q && (cnt_q == 8'h00) && (flags_q == ffm_pkg::ffm_flags_t'(6'h00));
	endsequence

	property p_rise_at_target;
		$rose(event_active_flag_q) |-> (cnt_q == debounce_target_count_q);
	endproperty
	a_rise_at_target: assert property (p_rise_at_target) else $error("event rose off target count");

	property p_clear_mode_drop;
		(sample_valid && !cond && debounce_lapse_mode_q && !cfg_q.latch_on && !reg_wr) |=> !event_active_flag_q;
	endproperty
	a_clear_mode_drop: assert property (p_clear_mode_drop) else $error("event held after lapse");

	property p_decrement;
		(sample_valid && !cond && !debounce_lapse_mode_q && cnt_q != 8'h00 && !clr_rd && !reg_wr)
			|=> (cnt_q == $past(cnt_q) - 8'h01);
	endproperty
	a_decrement: assert property (p_decrement) else $error("counter did not step down");

	property p_decay_hold;
		(event_active_flag_q && !cfg_q.latch_on && !debounce_lapse_mode_q && cnt_q > 8'h01 && !reg_wr)
			|=> event_active_flag_q;
	endproperty
	a_decay_hold: assert property (p_decay_hold) else $error("event cleared before decay");

	property p_saturate;
		(sample_valid && cond && cnt_q == debounce_target_count_q && !clr_rd && !reg_wr)
			|=> (cnt_q == $past(debounce_target_count_q));
	endproperty
	a_saturate: assert property (p_saturate) else $error("counter passed target");

	property p_latched_hold;
		(cfg_q.latch_on && event_active_flag_q && !rd_src && !reg_wr) |=> (event_active_flag_q && $stable(flags_q));
	endproperty
	a_latched_hold: assert property (p_latched_hold) else $error("latched source changed");

	property p_latched_clear;
		s_latched_read |=> s_all_cleared;
	endproperty
	a_latched_clear: assert property (p_latched_clear) else $error("read did not clear source");

	property p_unlatched_read;
		(rd_src && !cfg_q.latch_on && !sample_valid && !reg_wr)
			|=> ($stable(cnt_q) && $stable(event_active_flag_q) && $stable(flags_q));
	endproperty
	a_unlatched_read: assert property (p_unlatched_read) else $error("unlatched read had effect");

	property p_no_sample_idle;
		(!sample_valid && !rd_src) |=> $stable(cnt_q);
	endproperty
	a_no_sample_idle: assert property (p_no_sample_idle) else $error("counter moved without sample");

	property p_read_data;
		rd_src |=> (reg_rdata == $past(src_view));
	endproperty
	a_read_data: assert property (p_read_data) else $error("source read data wrong");

	// checked at the read data pins, so a broken mask or read mux shows up here
	property p_disabled_axis_zero;
		rd_src |=> ((reg_rdata[5:0] & {{2{$past(cfg_q.z_on)}}, {2{$past(cfg_q.y_on)}},
			{2{$past(cfg_q.x_on)}}}) == reg_rdata[5:0]);
	endproperty
	a_disabled_axis_zero: assert property (p_disabled_axis_zero) else $error("disabled axis reads nonzero");

	property p_irq_gate;
		##1 (irq_int1 == $past(event_active_flag_q && motion_irq_enable && motion_irq_route));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt pin mismatch");

endmodule : ffm_detector

// file: verif/ffm_host.sv
// host-side register master that drives the detector's register port
`timescale 1ns/1ps

module ffm_host (
	// clock
	input wire logic clk,
	// register port toward the detector
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// idle bus at time zero, address parked on an unmapped place
	initial begin
		reg_addr = 8'hff;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	// one byte write, strobe held across exactly one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d; // stale data must not look like a valid write
	endtask : wr

	// one completed read; data is registered at the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
endmodule : ffm_host

// file: verif/tb_top.sv
// self-checking bench for the freefall/motion detector with a behavioural model
`timescale 1ns/1ps

module tb_top;
	logic clk, arst_n, reg_wr, reg_rd, sample_valid, irq_en, irq_rt, irq_int1, irq_int2;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
	ffm_pkg::ffm_sample_s sample;
	int m_cfg, m_ths, m_tgt, m_cnt, m_ea, m_fl;
	int error_cnt = 0;
	int total_checks = 0;

	ffm_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));

	ffm_detector dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.sample(sample), .motion_irq_enable(irq_en), .motion_irq_route(irq_rt),
		.irq_int1(irq_int1), .irq_int2(irq_int2));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	// expected source image, disabled axes masked at readout
	function automatic logic [7:0] src_img();
		logic [7:0] v;
		v = {m_ea[0], 1'b0, m_fl[5:0]};
		for (int i = 0; i < 3; i++) if (!m_cfg[3+i]) v[2*i +: 2] = 2'b00;
		return v;
	endfunction : src_img

	// model of one sample: compare, combine, debounce, flags
	task automatic step(input ffm_pkg::ffm_sample_s s);
		int a, mag, ahi, hi, lo, en, cnd, fl;
		en = (m_cfg >> 3) & 7;
		hi = 0;
		lo = 1;
		fl = 0;
		for (int i = 0; i < 3; i++) begin
			a = signed'(s[8*i +: 8]);
			mag = (a < 0) ? -a : a; // -128 counts as 128
			ahi = (mag > (m_ths & 127)) ? 1 : 0;
			if (en[i] && ahi == 1) hi = 1;
			if (en[i] && ahi == 1) lo = 0;
			fl = fl | (ahi << (2*i+1)) | (((ahi == 1 && a < 0) ? 1 : 0) << (2*i));
		end
		cnd = (en == 0) ? 0 : (m_cfg[6] ? hi : lo);
		if (cnd == 1) m_cnt = (m_cnt < m_tgt) ? m_cnt + 1 : m_tgt;
		else m_cnt = m_ths[7] ? 0 : ((m_cnt > 0) ? m_cnt - 1 : 0);
		if (!(m_cfg[7] && m_ea == 1)) m_fl = fl;
		if (cnd == 1 && m_cnt == m_tgt) m_ea = 1;
		else if (!m_cfg[7] && (m_ths[7] || m_cnt == 0)) m_ea = 0;
	endtask : step

	// one random sample, then the interrupt pins two edges later
	task automatic sample_once();
		ffm_pkg::ffm_sample_s s;
		logic ie, rt;
		for (int i = 0; i < 3; i++) s[8*i +: 8] = 8'($urandom_range(0, 120) - 60);
		if ($urandom_range(0, 15) == 0) s[7:0] = 8'h80;
		ie = 1'($urandom_range(0, 1));
		rt = 1'($urandom_range(0, 1));
		@(negedge clk);
		sample = s;
		sample_valid = 1'b1;
		irq_en = ie;
		irq_rt = rt;
		@(negedge clk);
		sample_valid = 1'b0;
		sample = ~s; // stale sample must not linger
		step(s);
		@(negedge clk);
		chk({6'h00, irq_int1, irq_int2}, {6'h00, m_ea[0] & ie & rt, m_ea[0] & ie & ~rt});
	endtask : sample_once

	// watchdog: about 25 times the expected run length
	initial begin
		#1000000;
		error_cnt++;
		complete_run();
	end

	// main sequence
	initial begin
		arst_n = 1'b0;
		sample_valid = 1'b0;
		sample = '0;
		irq_en = 1'b0;
		irq_rt = 1'b0;
		void'($urandom(32'h0002_a4dd));
		repeat (3) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		for (int a = 8'h15; a <= 8'h19; a++) begin
			host.rd(8'(a), rdv);
			chk(rdv, 8'h00);
		end
		host.wr(8'h16, 8'hff);
		host.wr(8'h15, 8'hff);
		host.wr(8'h19, 8'hff);
		host.rd(8'h15, rdv);
		chk(rdv, 8'hf8);
		host.rd(8'h16, rdv);
		chk(rdv, 8'h00);
		host.rd(8'h19, rdv);
		chk(rdv, 8'h00);
		for (int k = 0; k < 16; k++) begin
			@(negedge clk);
			arst_n = 1'b0;
			@(negedge clk);
			arst_n = 1'b1;
			m_cnt = 0;
			m_ea = 0;
			m_fl = 0;
			m_cfg = (k[0] << 7) | (k[1] << 6) | ($urandom_range(0, 7) << 3);
			m_ths = (k[2] << 7) | $urandom_range(0, 40);
			m_tgt = $urandom_range(0, 3);
			host.wr(8'h15, 8'(m_cfg));
			host.wr(8'h17, 8'(m_ths));
			host.wr(8'h18, 8'(m_tgt));
			host.rd(8'h17, rdv);
			chk(rdv, 8'(m_ths));
			// config and target read back as written, low config bits stay zero
			host.rd(8'h15, rdv);
			chk(rdv, 8'(m_cfg));
			host.rd(8'h18, rdv);
			chk(rdv, 8'(m_tgt));
			for (int n = 0; n < 30; n++) begin
				sample_once();
				if ($urandom_range(0, 2) == 0) begin
					host.rd(8'h16, rdv);
					chk(rdv, src_img());
					if (m_cfg[7]) begin
						m_ea = 0;
						m_fl = 0;
						m_cnt = 0;
					end
				end
			end
		end
		complete_run();
	end
endmodule : tb_top
